//--- design/bcdadd_core.sv
// Execution datapath: decimal adjust, byte decrement, unsigned 8-by-8 divide
// Overview of operation
// - Low nibble above 9 or aux carry set: add 6 to accumulator.
// - Then high nibble above 9 or carry set: add 6 to high nibble.
// - Adjusted sum beyond two digits sets carry, low two digits kept.
// - Adjust additions may set carry, never clear it; overflow untouched.
// - Decrement subtracts one; zero wraps to all ones.
// - Decrement leaves carry, aux carry and overflow unchanged.
// - Decrement sources: accumulator, bank register, direct byte, indirect byte.
// - Decrementing an output port reads its output latch, not pins.
// - Direct decrement: opcode 0x15 plus address byte, two bytes, then a memory read and a write, each held until mem_ack_in.
// - Divide treats accumulator and secondary register as unsigned bytes.
// - Quotient goes to accumulator, remainder to secondary register.
// - Nonzero divisor: carry and overflow cleared.
// - Zero divisor: overflow set, carry cleared, results undefined.
// - Divide always clears carry.
`timescale 1ns/1ps
`default_nettype none
module bcdadd_core
    import bcdadd_pkg::*;
#(
    parameter int BANK_REGS = 8
) (
    input wire logic clk_sys_in,              // 40 MHz core clock
    input wire logic rst_in,                  // Async reset, active high
    input wire logic issue_in,                // Instruction strobe, one cycle
    input wire logic [7:0] opcode_in,         // First instruction byte
    input wire logic [7:0] operand_in,        // Second byte (direct address)
    input wire logic [7:0] acc_load_in,       // Accumulator preload data
    input wire logic acc_load_in_en_in,       // Accumulator preload strobe
    input wire logic [7:0] sec_load_in,       // Secondary register preload data
    input wire logic sec_load_en_in,          // Secondary register preload strobe
    input wire logic [2:0] flags_load_in,     // {carry, aux carry, overflow} preload
    input wire logic flags_load_en_in,        // Flag preload strobe
    input wire logic [7:0] bank_wdata_in,     // Bank register preload data
    input wire logic [2:0] bank_widx_in,      // Bank register preload index
    input wire logic bank_we_in,              // Bank register preload strobe
    input wire logic mem_ack_in,              // Memory read data valid / write done
    input wire logic [7:0] mem_rdata_in,      // Memory/SFR read data
    output logic busy_out,                    // Instruction in progress
    output logic done_out,                    // Instruction retired, one cycle
    output logic illegal_out,                 // Unknown opcode issued, one cycle
    output logic [7:0] acc_out,               // Accumulator
    output logic [7:0] sec_out,               // Secondary operand register
    output logic carry_flag_out,              // Carry flag
    output logic aux_carry_flag_out,          // Aux carry flag
    output logic overflow_flag_out,           // Overflow flag
    output logic mem_req_out,                 // Memory access request
    output logic mem_we_out,                  // Memory access is a write
    output logic mem_latch_sel_out,           // Read port output latch, not pins
    output logic [7:0] mem_addr_out,          // Memory address
    output logic [7:0] mem_wdata_out          // Memory write data
);
    // ****************************************
    // Checks and storage
    // ****************************************
    initial begin
        if (BANK_REGS != 8) $error("bcdadd_core: BANK_REGS must be 8");
    end

    bcdadd_state_t state_ff;
    logic [7:0] acc_ff;
    logic [7:0] sec_ff;
    logic carry_ff;
    logic aux_ff;
    logic ovf_ff;
    logic [7:0] bank_ff [BANK_REGS];
    logic [1:0] div_step_ff;
    logic [7:0] div_rem_ff;
    logic [7:0] div_quo_ff;
    logic [7:0] addr_ff;
    logic [7:0] wdata_ff;
    logic latch_sel_ff;
    logic done_ff;
    logic illegal_ff;

    // ****************************************
    // Decode
    // ****************************************
    function automatic logic is_bank_decr(input logic [7:0] opc);
        return (opc & MASK_BANK) == OPC_DECR_BANK;
    endfunction

    function automatic logic is_ind_decr(input logic [7:0] opc);
        return (opc & MASK_INDIRECT) == OPC_DECR_INDIRECT;
    endfunction

    logic start;
    logic op_da;
    logic op_decr_acc;
    logic op_decr_bank;
    logic op_decr_dir;
    logic op_decr_ind;
    logic op_div;
    assign start = issue_in && (state_ff == BCDADD_IDLE);
    assign op_da = start && opcode_in == OPC_DECIMAL_ADJUST;
    assign op_decr_acc = start && opcode_in == OPC_DECR_ACC;
    assign op_decr_bank = start && is_bank_decr(opcode_in);
    assign op_decr_dir = start && opcode_in == OPC_DECR_DIRECT;
    assign op_decr_ind = start && is_ind_decr(opcode_in);
    assign op_div = start && opcode_in == OPC_UNSIGNED_DIVIDE;

    // ****************************************
    // Decimal adjust arithmetic
    // ****************************************
    logic [8:0] da_low;
    logic [8:0] da_high;
    logic da_carry;
    always_comb begin
        da_low = {1'b0, acc_ff};
        if (acc_ff[3:0] > BCD_MAX_DIGIT || aux_ff) begin
            da_low = {1'b0, acc_ff} + {5'h00, BCD_FIX};
        end
        da_high = {1'b0, da_low[7:0]};
        if (da_low[7:4] > BCD_MAX_DIGIT || carry_ff || da_low[8]) begin
            da_high = {1'b0, da_low[7:0]} + {1'b0, BCD_FIX, 4'h0};
        end
        da_carry = carry_ff | da_low[8] | da_high[8];
    end

    // Bank decrement: original value from bank array, wraps at zero
    logic [7:0] bank_decr_val;
    assign bank_decr_val = bank_ff[opcode_in[2:0]] - ONE_BYTE;

    // ****************************************
    // Divide slice
    // ****************************************
    logic [7:0] step_rem;
    logic [7:0] step_quo;
    logic [7:0] slice_rem;
    logic [7:0] slice_quo;
    // Idle feeds the dividend so the issue edge already yields the first slice
    assign slice_rem = (state_ff == BCDADD_IDLE) ? 8'h00 : div_rem_ff;
    assign slice_quo = (state_ff == BCDADD_IDLE) ? acc_ff : div_quo_ff;
    bcdadd_div_step #(
        .BITS(DIV_BITS_PER_CYCLE)
    ) u_div_step (
        .rem_in(slice_rem),
        .quo_in(slice_quo),
        .divisor_in(sec_ff),
        .rem_out(step_rem),
        .quo_out(step_quo)
    );

    // ****************************************
    // Sequencing
    // ****************************************
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            state_ff <= BCDADD_IDLE;
            div_step_ff <= 2'h0;
        end else begin
            unique case (state_ff)
                BCDADD_IDLE: begin
                    div_step_ff <= 2'h0;
                    if (op_div && sec_ff != 8'h00) begin
                        state_ff <= BCDADD_DIV;
                    end else if (op_decr_dir || op_decr_ind) begin
                        state_ff <= BCDADD_MEMRD;
                    end
                end
                BCDADD_DIV: begin
                    div_step_ff <= div_step_ff + 2'h1;
                    // Four cycles total: issue cycle plus three slice steps
                    if (div_step_ff == DIV_LAST_STEP - 2'h1) begin
                        state_ff <= BCDADD_IDLE;
                    end
                end
                BCDADD_MEMRD: begin
                    if (mem_ack_in) state_ff <= BCDADD_MEMWR;
                end
                BCDADD_MEMWR: begin
                    if (mem_ack_in) state_ff <= BCDADD_IDLE;
                end
                default: state_ff <= BCDADD_IDLE;
            endcase
        end
    end

    // Memory access for direct/indirect decrement
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            addr_ff <= 8'h00;
            wdata_ff <= 8'h00;
            latch_sel_ff <= 1'b0;
        end else begin
            if (op_decr_dir) begin
                addr_ff <= operand_in;
                latch_sel_ff <= operand_in[7];
            end else if (op_decr_ind) begin
                addr_ff <= bank_ff[{2'h0, opcode_in[0]}];
                latch_sel_ff <= 1'b0;
            end
            if (state_ff == BCDADD_MEMRD && mem_ack_in) begin
                wdata_ff <= mem_rdata_in - ONE_BYTE;
            end
        end
    end

    // Accumulator and secondary register
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            acc_ff <= 8'h00;
            sec_ff <= 8'h00;
            div_rem_ff <= 8'h00;
            div_quo_ff <= 8'h00;
        end else begin
            if (acc_load_in_en_in && state_ff == BCDADD_IDLE) acc_ff <= acc_load_in;
            if (sec_load_en_in && state_ff == BCDADD_IDLE) sec_ff <= sec_load_in;
            if (op_da) acc_ff <= da_high[7:0];
            if (op_decr_acc) acc_ff <= acc_ff - ONE_BYTE;
            if (op_div) begin
                // Issue cycle runs the first slice straight off the accumulator
                div_rem_ff <= step_rem;
                div_quo_ff <= step_quo;
            end
            if (state_ff == BCDADD_DIV) begin
                div_rem_ff <= step_rem;
                div_quo_ff <= step_quo;
            end
            if (state_ff == BCDADD_DIV && div_step_ff == DIV_LAST_STEP - 2'h1) begin
                acc_ff <= step_quo;
                sec_ff <= step_rem;
            end
        end
    end

    // Bank registers: preload port and register decrement
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < BANK_REGS; i++) bank_ff[i] <= 8'h00;
        end else begin
            if (bank_we_in && state_ff == BCDADD_IDLE) bank_ff[bank_widx_in] <= bank_wdata_in;
            if (op_decr_bank) bank_ff[opcode_in[2:0]] <= bank_decr_val;
        end
    end

    // Flags: decrement never touches them
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            carry_ff <= 1'b0;
            aux_ff <= 1'b0;
            ovf_ff <= 1'b0;
        end else begin
            if (flags_load_en_in && state_ff == BCDADD_IDLE) begin
                {carry_ff, aux_ff, ovf_ff} <= flags_load_in;
            end
            if (op_da) carry_ff <= da_carry;
            if (op_div) begin
                carry_ff <= 1'b0;
                ovf_ff <= (sec_ff == 8'h00);
            end
        end
    end

    // Retire pulses
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            done_ff <= 1'b0;
            illegal_ff <= 1'b0;
        end else begin
            done_ff <= op_da || op_decr_acc || op_decr_bank
                || (op_div && sec_ff == 8'h00)
                || (state_ff == BCDADD_DIV && div_step_ff == DIV_LAST_STEP - 2'h1)
                || (state_ff == BCDADD_MEMWR && mem_ack_in);
            illegal_ff <= start && !(op_da || op_decr_acc || op_decr_bank
                || op_decr_dir || op_decr_ind || op_div);
        end
    end

    assign busy_out = state_ff != BCDADD_IDLE;
    assign done_out = done_ff;
    assign illegal_out = illegal_ff;
    assign acc_out = acc_ff;
    assign sec_out = sec_ff;
    assign carry_flag_out = carry_ff;
    assign aux_carry_flag_out = aux_ff;
    assign overflow_flag_out = ovf_ff;
    assign mem_req_out = state_ff == BCDADD_MEMRD || state_ff == BCDADD_MEMWR;
    assign mem_we_out = state_ff == BCDADD_MEMWR;
    assign mem_latch_sel_out = latch_sel_ff;
    assign mem_addr_out = addr_ff;
    assign mem_wdata_out = wdata_ff;
endmodule
`default_nettype wire

//--- design/bcdadd_pkg.sv
// Package: opcodes, field positions and timing counts for the adjust/decrement/divide datapath
package bcdadd_pkg;
    localparam logic [7:0] OPC_DECIMAL_ADJUST = 8'hd4;
    localparam logic [7:0] OPC_DECR_ACC = 8'h14;
    localparam logic [7:0] OPC_DECR_DIRECT = 8'h15;
    localparam logic [7:0] OPC_DECR_INDIRECT = 8'h16;
    localparam logic [7:0] OPC_DECR_BANK = 8'h18;
    localparam logic [7:0] OPC_UNSIGNED_DIVIDE = 8'h84;
    localparam logic [7:0] MASK_BANK = 8'hf8;
    localparam logic [7:0] MASK_INDIRECT = 8'hfe;
    localparam logic [3:0] BCD_MAX_DIGIT = 4'h9;
    localparam logic [3:0] BCD_FIX = 4'h6;
    localparam logic [7:0] ONE_BYTE = 8'h01;
    localparam int DIV_CYCLES = 4;
    localparam int DIV_BITS_PER_CYCLE = 2;
    localparam logic [1:0] DIV_LAST_STEP = 2'h3;
    typedef enum logic [3:0] {
        BCDADD_IDLE = 4'b0001,
        BCDADD_DIV = 4'b0010,
        BCDADD_MEMRD = 4'b0100,
        BCDADD_MEMWR = 4'b1000
    } bcdadd_state_t;
endpackage

//--- design/bcdadd_div_step.sv
// Combinational restoring-division slice: a fixed number of quotient bits per call
`timescale 1ns/1ps
`default_nettype none
module bcdadd_div_step #(
    parameter int BITS = 2
) (
    input wire logic [7:0] rem_in,     // Partial remainder
    input wire logic [7:0] quo_in,     // Dividend bits shifting out, quotient in
    input wire logic [7:0] divisor_in, // Divisor
    output logic [7:0] rem_out,        // Updated remainder
    output logic [7:0] quo_out         // Updated quotient/dividend
);
    initial begin
        if (BITS < 1 || BITS > 8) $error("bcdadd_div_step: BITS out of range");
    end

    always_comb begin
        logic [8:0] trial;
        logic [7:0] r;
        logic [7:0] q;
        trial = 9'h000;
        r = rem_in;
        q = quo_in;
        for (int i = 0; i < BITS; i++) begin
            trial = {r, q[7]} - {1'b0, divisor_in};
            if (!trial[8]) begin
                r = trial[7:0];
                q = {q[6:0], 1'b1};
            end else begin
                r = {r[6:0], q[7]};
                q = {q[6:0], 1'b0};
            end
        end
        rem_out = r;
        quo_out = q;
    end
endmodule
`default_nettype wire

//--- dv/bcdadd_checker.sv
// Checker: timing and flag relations of the adjust/decrement/divide datapath
`timescale 1ns/1ps
`default_nettype none
module bcdadd_checker (
    input wire logic clk_sys_in,          // Core clock
    input wire logic rst_in,              // Async reset
    input wire logic issue_in,            // Instruction strobe
    input wire logic [7:0] opcode_in,     // Opcode
    input wire logic busy_out,            // Busy level
    input wire logic done_out,            // Retire pulse
    input wire logic [7:0] acc_out,       // Accumulator
    input wire logic [7:0] sec_out,       // Secondary register
    input wire logic carry_flag_out,      // Carry
    input wire logic aux_carry_flag_out,  // Aux carry
    input wire logic overflow_flag_out,   // Overflow
    input wire logic mem_req_out,         // Memory request
    input wire logic mem_latch_sel_out,   // Latch select
    input wire logic [7:0] mem_addr_out   // Memory address
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    logic take;
    // An issue while busy is dropped, so only accepted ones start a check
    assign take = issue_in && !busy_out;
    da_flags_a: assert property (take && opcode_in == 8'hd4 |=>
        $stable(overflow_flag_out) && (carry_flag_out || !$past(carry_flag_out)))
        else $error("adjust changed overflow or cleared carry");
    da_retire_a: assert property (take && opcode_in == 8'hd4 |=> done_out && !busy_out)
        else $error("adjust not retired in one cycle");
    decr_acc_a: assert property (take && opcode_in == 8'h14 |=>
        acc_out == $past(acc_out) - 8'h01)
        else $error("accumulator decrement wrong");
    decr_flags_a: assert property (take && (opcode_in == 8'h14 || opcode_in[7:3] == 5'h03) |=>
        $stable({carry_flag_out, aux_carry_flag_out, overflow_flag_out}))
        else $error("decrement touched a flag");
    div_timing_a: assert property (take && opcode_in == 8'h84 && sec_out != 8'h00 |=>
        busy_out[*3] ##1 (done_out && !busy_out))
        else $error("divide not four cycles");
    div_result_a: assert property (take && opcode_in == 8'h84 && sec_out != 8'h00 |->
        ##4 acc_out == $past(acc_out, 4) / $past(sec_out, 4)
        && sec_out == $past(acc_out, 4) % $past(sec_out, 4))
        else $error("divide quotient or remainder wrong");
    div_flags_a: assert property (take && opcode_in == 8'h84 |=>
        !carry_flag_out && overflow_flag_out == ($past(sec_out) == 8'h00))
        else $error("divide flags wrong");
    latch_sel_a: assert property (mem_req_out && !mem_addr_out[7] |-> !mem_latch_sel_out)
        else $error("latch select outside port space");
endmodule
bind bcdadd_core bcdadd_checker u_checker (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .issue_in(issue_in), .opcode_in(opcode_in), .busy_out(busy_out), .done_out(done_out),
    .acc_out(acc_out), .sec_out(sec_out), .carry_flag_out(carry_flag_out),
    .aux_carry_flag_out(aux_carry_flag_out), .overflow_flag_out(overflow_flag_out),
    .mem_req_out(mem_req_out), .mem_latch_sel_out(mem_latch_sel_out),
    .mem_addr_out(mem_addr_out));
`default_nettype wire

//--- dv/testbench.sv
// Testbench: self-checking scenarios for the adjust/decrement/divide datapath
`timescale 1ns/1ps
`default_nettype none
module testbench
    import bcdadd_pkg::*;
;
    logic clk_sys_in = 1'b0, rst_in = 1'b1, issue_in = 1'b0, mem_ack_in = 1'b0;
    logic acc_load_in_en_in = 1'b0, sec_load_en_in = 1'b0, flags_load_en_in = 1'b0;
    logic bank_we_in = 1'b0;
    logic [7:0] opcode_in = 8'h00, operand_in = 8'h00, acc_load_in = 8'h00;
    logic [7:0] sec_load_in = 8'h00, bank_wdata_in = 8'h00, mem_rdata_in = 8'h00;
    logic [2:0] flags_load_in = 3'h0, bank_widx_in = 3'h0;
    logic busy_out, done_out, illegal_out, carry_flag_out, aux_carry_flag_out;
    logic overflow_flag_out, mem_req_out, mem_we_out, mem_latch_sel_out;
    logic [7:0] acc_out, sec_out, mem_addr_out, mem_wdata_out;
    logic [7:0] mem [256];
    int err_count = 0, n_tests = 0;
    // Adjust cases: {acc, carry, aux carry, expected acc, expected carry}
    localparam logic [18:0] DA_T [7] = '{{8'hbe, 2'b00, 8'h24, 1'b1}, {8'hc9, 2'b00, 8'h29, 1'b1},
        {8'h09, 2'b01, 8'h0f, 1'b0}, {8'h9a, 2'b00, 8'h00, 1'b1}, {8'h12, 2'b10, 8'h72, 1'b1},
        {8'h45, 2'b00, 8'h45, 1'b0}, {8'hfa, 2'b00, 8'h60, 1'b1}};
    always #12.5 clk_sys_in = ~clk_sys_in;
    bcdadd_core u_dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .issue_in(issue_in),
        .opcode_in(opcode_in), .operand_in(operand_in), .acc_load_in(acc_load_in),
        .acc_load_in_en_in(acc_load_in_en_in), .sec_load_in(sec_load_in),
        .sec_load_en_in(sec_load_en_in), .flags_load_in(flags_load_in),
        .flags_load_en_in(flags_load_en_in), .bank_wdata_in(bank_wdata_in),
        .bank_widx_in(bank_widx_in), .bank_we_in(bank_we_in), .mem_ack_in(mem_ack_in),
        .mem_rdata_in(mem_rdata_in), .busy_out(busy_out), .done_out(done_out),
        .illegal_out(illegal_out), .acc_out(acc_out), .sec_out(sec_out),
        .carry_flag_out(carry_flag_out), .aux_carry_flag_out(aux_carry_flag_out),
        .overflow_flag_out(overflow_flag_out), .mem_req_out(mem_req_out),
        .mem_we_out(mem_we_out), .mem_latch_sel_out(mem_latch_sel_out),
        .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out));
    // ************************************************************
    // Memory: port pins read inverted, so a pin read cannot pass for a latch read
    // ************************************************************
    always @(negedge clk_sys_in) begin
        if (mem_req_out && !mem_ack_in) begin
            mem_ack_in <= 1'b1;
            mem_rdata_in <= (mem_addr_out[7] && !mem_latch_sel_out) ?
                ~mem[mem_addr_out] : mem[mem_addr_out];
            if (mem_we_out) begin
                mem[mem_addr_out] <= mem_wdata_out;
            end
        end else begin
            mem_ack_in <= 1'b0;
            mem_rdata_in <= ~mem_rdata_in;
        end
    end
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic preload(input logic [7:0] a, input logic [7:0] b, input logic [2:0] f);
        @(negedge clk_sys_in);
        acc_load_in = a;
        sec_load_in = b;
        flags_load_in = f;
        {acc_load_in_en_in, sec_load_en_in, flags_load_en_in} = 3'b111;
        @(negedge clk_sys_in);
        {acc_load_in_en_in, sec_load_en_in, flags_load_en_in} = 3'b000;
    endtask
    task automatic wait_done();
        for (int i = 0; i < 40 && done_out !== 1'b1; i++) @(negedge clk_sys_in);
        chk("done_out", 8'h01, {7'h00, done_out});
    endtask
    task automatic run(input logic [7:0] op, input logic [7:0] opnd);
        @(negedge clk_sys_in);
        issue_in = 1'b1;
        opcode_in = op;
        operand_in = opnd;
        @(negedge clk_sys_in);
        issue_in = 1'b0;
        wait_done();
    endtask
    task automatic chk_flags(input logic [2:0] f);
        chk("flags", {5'h00, f}, {5'h00, carry_flag_out, aux_carry_flag_out, overflow_flag_out});
    endtask
    task automatic t_adjust();
        for (int k = 0; k < 7; k++) begin
            preload(DA_T[k][18:11], 8'h00, {DA_T[k][10:9], 1'b1});
            run(OPC_DECIMAL_ADJUST, 8'h00);
            chk("da acc", DA_T[k][8:1], acc_out);
            chk("da c ov", {6'h00, DA_T[k][0], 1'b1}, {6'h00, carry_flag_out, overflow_flag_out});
        end
    endtask
    task automatic t_dec();
        preload(8'h00, 8'h00, 3'b111);
        run(OPC_DECR_ACC, 8'h00);
        run(OPC_DECR_ACC, 8'h00);
        chk("dec acc", 8'hfe, acc_out);
        chk_flags(3'b111);
        @(negedge clk_sys_in);
        bank_widx_in = 3'h0;
        bank_wdata_in = 8'h7f;
        bank_we_in = 1'b1;
        @(negedge clk_sys_in);
        bank_we_in = 1'b0;
        mem[8'h7e] = 8'h00;
        mem[8'h7f] = 8'h40;
        mem[8'h30] = 8'h00;
        mem[8'h90] = 8'h55;
        preload(8'h00, 8'h00, 3'b010);
        run(OPC_DECR_INDIRECT, 8'h00);
        run(OPC_DECR_BANK, 8'h00);
        run(OPC_DECR_INDIRECT, 8'h00);
        chk("ram 7e", 8'hff, mem[8'h7e]);
        chk("ram 7f", 8'h3f, mem[8'h7f]);
        run(OPC_DECR_DIRECT, 8'h30);
        run(OPC_DECR_DIRECT, 8'h90);
        chk("ram 30", 8'hff, mem[8'h30]);
        chk("port 90", 8'h54, mem[8'h90]);
        chk("port addr", 8'h90, mem_addr_out);
        chk("port wdata", 8'h54, mem_wdata_out);
        chk("latch sel", 8'h01, {7'h00, mem_latch_sel_out});
        chk("mem idle", 8'h00, {6'h00, mem_req_out, mem_we_out});
        chk_flags(3'b010);
    endtask
    task automatic t_div();
        preload(8'hfb, 8'h12, 3'b111);
        @(negedge clk_sys_in);
        issue_in = 1'b1;
        opcode_in = OPC_UNSIGNED_DIVIDE;
        // Held into the busy cycle as a decrement, which must be dropped
        @(negedge clk_sys_in);
        opcode_in = OPC_DECR_ACC;
        @(negedge clk_sys_in);
        issue_in = 1'b0;
        wait_done();
        chk("quotient", 8'd251 / 8'd18, acc_out);
        chk("remainder", 8'd251 % 8'd18, sec_out);
        chk("div c ov", 8'h00, {6'h00, carry_flag_out, overflow_flag_out});
        chk("div busy", 8'h00, {7'h00, busy_out});
        preload(8'hff, 8'h01, 3'b000);
        run(OPC_UNSIGNED_DIVIDE, 8'h00);
        chk("quotient", 8'hff, acc_out);
        chk("remainder", 8'h00, sec_out);
        preload(8'h07, 8'h00, 3'b100);
        run(OPC_UNSIGNED_DIVIDE, 8'h00);
        chk("div0 c ov", 8'h01, {6'h00, carry_flag_out, overflow_flag_out});
    endtask
    task automatic t_illegal();
        logic seen;
        seen = 1'b0;
        @(negedge clk_sys_in);
        issue_in = 1'b1;
        opcode_in = 8'ha5;
        @(negedge clk_sys_in);
        issue_in = 1'b0;
        for (int i = 0; i < 3; i++) begin
            seen = seen | (illegal_out === 1'b1);
            @(negedge clk_sys_in);
        end
        chk("illegal", 8'h01, {7'h00, seen});
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(negedge clk_sys_in);
        rst_in = 1'b0;
        chk("acc rst", 8'h00, acc_out);
        chk_flags(3'b000);
        t_adjust();
        t_dec();
        t_div();
        t_illegal();
        conclude();
    end
    // Tests take about a hundred cycles; 4000 cycles means a hang
    initial begin
        #100000;
        err_count++;
        conclude();
    end
endmodule
`default_nettype wire
